// >>> ddr_sram_regs.svh
// timing counts and reset values for the echo clock and burst block
`ifndef DDR_SRAM_REGS_SVH
`define DDR_SRAM_REGS_SVH
`define CAL_PERIOD_CYCLES 1024
`define STATIC_HIGH_CYCLES 4
`define ECHO_POS_RESET 1'b0
`define ECHO_NEG_RESET 1'b1
`define LOOP_ENABLE_RESET 1'b1
`define TRIM_RESET '0
`endif

// >>> ddr_sram_pkg.sv
// state types for the echo clock and burst block
package ddr_sram_pkg;
  typedef enum logic [2:0] {
    CAL_COUNT = 3'b001,
    CAL_SEND = 3'b010,
    CAL_WAIT_ACK = 3'b100
  } cal_state_e;
  typedef enum logic [2:0] {
    OUT_IDLE = 3'b001,
    OUT_FIRST = 3'b010,
    OUT_SECOND = 3'b100
  } out_state_e;
endpackage : ddr_sram_pkg

// >>> sync_bit.sv
// two flip-flop synchroniser with a constant reset value
`timescale 1ns/1ps
`default_nettype none
module sync_bit #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RESET_VAL;
      q_reg <= RESET_VAL;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule : sync_bit
`default_nettype wire

// >>> burst_buffer.sv
// small synchronous buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module burst_buffer #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int NW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] wr_ptr_next;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW-1:0] rd_ptr_next;
  logic [NW-1:0] count_reg;
  logic [NW-1:0] count_next;
  logic push;
  logic pop;

  assign in_ready = (count_reg != NW'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
endmodule : burst_buffer
`default_nettype wire

// >>> ddr_sram_echo_clock_burst.sv
// burst-of-two sram core with echo clocks and impedance recalibration
// What this block does
// RULE1 - echo clock rising edges are launched on the same edges as read data.
// RULE2 - echo clocks keep toggling while their reference runs, reads or not.
// RULE3 - echo clocks freeze whenever their reference clock stops.
// RULE4 - the impedance code is resampled once every 1024 clock cycles.
// RULE5 - with the loop bypass pin low the loop is off and K timing is used.
// RULE6 - the controller keeps the loop bypass pin high for normal use.
// RULE7 - the second word of a burst uses the address with bit 0 inverted.
// RULE8 - the controller supplies a stable clock from the very start.
// RULE9 - load low at a K rise starts a two-word read (dir high) or write.
// RULE10 - first read word goes with the C# rise, second with the C rise.
// RULE11 - with the output clock pair held high, output timing follows K.
// RULE12 - commands register at K rise, write words at K and K# rises.
// RULE13 - echo clocks are built from whichever pair is the output reference.
`timescale 1ns/1ps
`default_nettype none
`include "ddr_sram_regs.svh"
module ddr_sram_echo_clock_burst
  import ddr_sram_pkg::*;
#(
  parameter int DW = 36,
  parameter int AW = 19,
  parameter int CW = 8,
  parameter int CAL_PERIOD = `CAL_PERIOD_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic LINK_CLK,
  input wire logic LOAD_N,
  input wire logic READ_NWRITE,
  input wire logic [AW-1:0] ADDR,
  input wire logic [DW-1:0] DATA_IN,
  input wire logic OUT_CLK_POS,
  input wire logic OUT_CLK_NEG,
  input wire logic LOOP_BYPASS_N,
  input wire logic [CW-1:0] IMPEDANCE_PIN,
  output logic [DW-1:0] DATA_OUT,
  output logic DATA_OE,
  output logic ECHO_OUT_POS,
  output logic ECHO_OUT_NEG,
  output logic [CW-1:0] IMPEDANCE_TRIM,
  output logic LOOP_ENABLE
);
  localparam int CNTW = $clog2(CAL_PERIOD);
  localparam int HW = $clog2(`STATIC_HIGH_CYCLES);
  localparam int EW = AW - 1;

  // ---------------- core domain: calibration and loop control
  logic bypass_core_n;
  logic ack_core;
  logic [CW-1:0] imp_code;
  cal_state_e cal_state_reg;
  cal_state_e cal_state_next;
  logic [CNTW-1:0] cal_cnt_reg;
  logic [CNTW-1:0] cal_cnt_next;
  logic [CW-1:0] cal_word_reg;
  logic [CW-1:0] cal_word_next;
  logic req_tog_reg;
  logic req_tog_next;
  logic loop_en_reg;
  logic loop_en_next;
  logic cal_last;
  logic req_seen_reg;

  sync_bit #(.WIDTH(1), .RESET_VAL(1'b1)) u_bypass_core (
    .clk(REF_CLK), .rst(RESET), .d(LOOP_BYPASS_N), .q(bypass_core_n));
  sync_bit #(.WIDTH(1), .RESET_VAL(1'b0)) u_ack_core (
    .clk(REF_CLK), .rst(RESET), .d(req_seen_reg), .q(ack_core));
  sync_bit #(.WIDTH(CW), .RESET_VAL('0)) u_imp (
    .clk(REF_CLK), .rst(RESET), .d(IMPEDANCE_PIN), .q(imp_code));

  always_comb begin
    cal_last = (cal_cnt_reg == CNTW'(CAL_PERIOD - 1));
    cal_cnt_next = cal_last ? '0 : cal_cnt_reg + 1'b1;
    cal_state_next = cal_state_reg;
    cal_word_next = cal_word_reg;
    req_tog_next = req_tog_reg;
    loop_en_next = bypass_core_n; // see RULE5
    case (cal_state_reg)
      CAL_COUNT: begin
        if (cal_last) begin
          cal_state_next = CAL_SEND; // see RULE4
        end
      end
      CAL_SEND: begin
        cal_word_next = imp_code;
        req_tog_next = ~req_tog_reg;
        cal_state_next = CAL_WAIT_ACK;
      end
      CAL_WAIT_ACK: begin
        if (ack_core == req_tog_reg) begin
          cal_state_next = CAL_COUNT;
        end
      end
      default: cal_state_next = CAL_COUNT;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      // first pass waits for the code synchroniser to settle
      cal_state_reg <= CAL_COUNT;
      cal_cnt_reg <= CNTW'(CAL_PERIOD - 4);
      cal_word_reg <= `TRIM_RESET;
      req_tog_reg <= 1'b0;
      loop_en_reg <= `LOOP_ENABLE_RESET;
    end else begin
      cal_state_reg <= cal_state_next;
      cal_cnt_reg <= cal_cnt_next;
      cal_word_reg <= cal_word_next;
      req_tog_reg <= req_tog_next;
      loop_en_reg <= loop_en_next;
    end
  end

  // ---------------- link domain: commands, memory, echo and output
  logic link_rst;
  logic c_pos_s;
  logic c_neg_s;
  logic bypass_link_n;
  logic req_link;
  logic req_seen_next;
  logic [CW-1:0] trim_reg;
  logic [CW-1:0] trim_next;
  logic c_pos_prev_reg;
  logic c_neg_prev_reg;
  logic [HW-1:0] high_cnt_reg;
  logic [HW-1:0] high_cnt_next;
  logic single_mode_reg;
  logic single_mode_next;
  logic k_mode;
  logic ref_tick;
  logic echo_pos_reg;
  logic echo_pos_next;
  logic echo_neg_reg;
  logic echo_neg_next;
  logic rd_req_reg;
  logic rd_req_next;
  logic wr_req_reg;
  logic wr_req_next;
  logic [AW-1:0] cmd_addr_reg;
  logic [AW-1:0] cmd_addr_next;
  logic wr_stage_reg;
  logic wr_stage_next;
  logic [AW-1:0] wr_addr_reg;
  logic [AW-1:0] wr_addr_next;
  logic [DW-1:0] word1_reg;
  logic [DW-1:0] word1_next;
  logic [DW-1:0] word2_reg;
  logic [DW-1:0] word2_next;
  logic [2*DW-1:0] wr_entry;
  logic [2*DW-1:0] mem [0:(2**EW)-1];
  logic rd_valid_reg;
  logic rd_valid_next;
  logic [2*DW-1:0] rd_pair_reg;
  logic [2*DW-1:0] rd_pair_next;
  logic [2*DW-1:0] rd_entry;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [2*DW-1:0] buf_out_data;
  logic pop;
  out_state_e ser_state_reg;
  out_state_e ser_state_next;
  logic [DW-1:0] second_reg;
  logic [DW-1:0] second_next;
  logic [DW-1:0] dout_reg;
  logic [DW-1:0] dout_next;
  logic doe_reg;
  logic doe_next;

  sync_bit #(.WIDTH(1), .RESET_VAL(1'b1)) u_link_rst (
    .clk(LINK_CLK), .rst(RESET), .d(1'b0), .q(link_rst));
  sync_bit #(.WIDTH(1), .RESET_VAL(1'b0)) u_cpos (
    .clk(LINK_CLK), .rst(link_rst), .d(OUT_CLK_POS), .q(c_pos_s));
  sync_bit #(.WIDTH(1), .RESET_VAL(1'b0)) u_cneg (
    .clk(LINK_CLK), .rst(link_rst), .d(OUT_CLK_NEG), .q(c_neg_s));
  sync_bit #(.WIDTH(1), .RESET_VAL(1'b1)) u_bypass_link (
    .clk(LINK_CLK), .rst(link_rst), .d(LOOP_BYPASS_N), .q(bypass_link_n));
  sync_bit #(.WIDTH(1), .RESET_VAL(1'b0)) u_req_link (
    .clk(LINK_CLK), .rst(link_rst), .d(req_tog_reg), .q(req_link));

  // reference select: K when C is parked high or the loop is bypassed
  always_comb begin
    k_mode = single_mode_reg || !bypass_link_n; // see RULE5
    ref_tick = k_mode ? 1'b1 : // see RULE13
      ((c_pos_s && !c_pos_prev_reg) || (c_neg_s && !c_neg_prev_reg));
    high_cnt_next = '0;
    single_mode_next = 1'b0;
    if (c_pos_s && c_neg_s) begin
      single_mode_next = (high_cnt_reg == HW'(`STATIC_HIGH_CYCLES - 1));
      high_cnt_next = single_mode_next ? high_cnt_reg : high_cnt_reg + 1'b1;
    end
    echo_pos_next = ref_tick ? ~echo_pos_reg : echo_pos_reg; // see RULE2
    echo_neg_next = ~echo_pos_next;
    req_seen_next = req_link;
    // word from the core is stable until the ack toggle returns
    trim_next = (req_link != req_seen_reg) ? cal_word_reg : trim_reg;
  end

  // command capture at K rise and the write pipeline
  always_comb begin
    rd_req_next = !LOAD_N && READ_NWRITE; // see RULE12
    wr_req_next = !LOAD_N && !READ_NWRITE;
    cmd_addr_next = LOAD_N ? cmd_addr_reg : ADDR;
    wr_stage_next = wr_req_reg;
    wr_addr_next = wr_req_reg ? cmd_addr_reg : wr_addr_reg;
    word1_next = wr_req_reg ? DATA_IN : word1_reg; // see RULE12
    word2_next = DATA_IN;
    if (wr_addr_reg[0]) begin
      wr_entry = {word1_reg, word2_reg}; // see RULE7
    end else begin
      wr_entry = {word2_reg, word1_reg};
    end
    rd_entry = mem[cmd_addr_reg[AW-1:1]];
    rd_valid_next = rd_valid_reg && !buf_in_ready;
    rd_pair_next = rd_pair_reg;
    if (rd_req_reg && (!rd_valid_reg || buf_in_ready)) begin
      rd_valid_next = 1'b1;
      rd_pair_next = cmd_addr_reg[0] ? // see RULE7
        {rd_entry[DW-1:0], rd_entry[2*DW-1:DW]} : rd_entry;
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (wr_stage_reg) begin
      mem[wr_addr_reg[AW-1:1]] <= wr_entry;
    end
  end

  // second write word is taken on the K# rise, the falling edge of K
  always_ff @(negedge LINK_CLK or posedge link_rst) begin
    if (link_rst) begin
      word2_reg <= '0;
    end else begin
      word2_reg <= word2_next; // see RULE12
    end
  end

  burst_buffer #(.WIDTH(2 * DW), .DEPTH(2)) u_buffer (
    .clk(LINK_CLK), .rst(link_rst),
    .in_valid(rd_valid_reg), .in_ready(buf_in_ready),
    .in_data(rd_pair_reg),
    .out_valid(buf_out_valid), .out_ready(pop),
    .out_data(buf_out_data));

  // output serializer: first word with the neg echo rise, then the second
  always_comb begin
    pop = 1'b0;
    ser_state_next = ser_state_reg;
    second_next = second_reg;
    dout_next = dout_reg;
    doe_next = doe_reg;
    case (ser_state_reg)
      OUT_IDLE, OUT_SECOND: begin
        if (ref_tick) begin
          if (buf_out_valid && echo_pos_reg) begin
            pop = 1'b1;
            dout_next = buf_out_data[DW-1:0]; // see RULE10
            second_next = buf_out_data[2*DW-1:DW];
            doe_next = 1'b1;
            ser_state_next = OUT_FIRST;
          end else begin
            doe_next = 1'b0;
            ser_state_next = OUT_IDLE;
          end
        end
      end
      OUT_FIRST: begin
        if (ref_tick) begin
          dout_next = second_reg; // see RULE1
          ser_state_next = OUT_SECOND;
        end
      end
      default: ser_state_next = OUT_IDLE;
    endcase
  end

  always_ff @(posedge LINK_CLK or posedge link_rst) begin
    if (link_rst) begin
      req_seen_reg <= 1'b0;
      trim_reg <= `TRIM_RESET;
      c_pos_prev_reg <= 1'b0;
      c_neg_prev_reg <= 1'b0;
      high_cnt_reg <= '0;
      single_mode_reg <= 1'b0;
      echo_pos_reg <= `ECHO_POS_RESET;
      echo_neg_reg <= `ECHO_NEG_RESET;
      rd_req_reg <= 1'b0;
      wr_req_reg <= 1'b0;
      cmd_addr_reg <= '0;
      wr_stage_reg <= 1'b0;
      wr_addr_reg <= '0;
      word1_reg <= '0;
      rd_valid_reg <= 1'b0;
      rd_pair_reg <= '0;
      ser_state_reg <= OUT_IDLE;
      second_reg <= '0;
      dout_reg <= '0;
      doe_reg <= 1'b0;
    end else begin
      req_seen_reg <= req_seen_next;
      trim_reg <= trim_next;
      c_pos_prev_reg <= c_pos_s; // see RULE3
      c_neg_prev_reg <= c_neg_s;
      high_cnt_reg <= high_cnt_next;
      single_mode_reg <= single_mode_next; // see RULE11
      echo_pos_reg <= echo_pos_next;
      echo_neg_reg <= echo_neg_next;
      rd_req_reg <= rd_req_next;
      wr_req_reg <= wr_req_next;
      cmd_addr_reg <= cmd_addr_next;
      wr_stage_reg <= wr_stage_next;
      wr_addr_reg <= wr_addr_next;
      word1_reg <= word1_next;
      rd_valid_reg <= rd_valid_next;
      rd_pair_reg <= rd_pair_next;
      ser_state_reg <= ser_state_next;
      second_reg <= second_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
    end
  end

  assign DATA_OUT = dout_reg;
  assign DATA_OE = doe_reg;
  assign ECHO_OUT_POS = echo_pos_reg;
  assign ECHO_OUT_NEG = echo_neg_reg;
  assign IMPEDANCE_TRIM = trim_reg;
  assign LOOP_ENABLE = loop_en_reg;

  // ---------------- checks
  sequence c_parked_s;
    (c_pos_s && c_neg_s) [*4];
  endsequence
  sequence write_cmd_s;
    !LOAD_N && !READ_NWRITE;
  endsequence

  data_on_echo_a: assert property ( // see RULE1
    @(posedge LINK_CLK) disable iff (link_rst)
    (doe_reg && $changed(dout_reg)) |-> $changed(echo_pos_reg))
    else $error("read data moved without an echo edge");
  echo_free_a: assert property ( // see RULE2
    @(posedge LINK_CLK) disable iff (link_rst)
    k_mode |=> (echo_pos_reg != $past(echo_pos_reg)) && (echo_neg_reg == !echo_pos_reg))
    else $error("echo clock did not toggle with its reference running");
  echo_stop_a: assert property ( // see RULE3
    @(posedge LINK_CLK) disable iff (link_rst)
    (!k_mode && $stable(c_pos_s) && $stable(c_neg_s)) |=> $stable(echo_pos_reg))
    else $error("echo clock moved while the output clock was still");
  cal_period_a: assert property ( // see RULE4
    @(posedge REF_CLK) disable iff (RESET)
    (cal_state_reg == CAL_COUNT && cal_last) |=> (cal_state_reg == CAL_SEND)
      ##1 (cal_state_reg == CAL_WAIT_ACK) && (cal_cnt_reg == CNTW'(1)))
    else $error("impedance recalibration missed its period");
  loop_off_a: assert property ( // see RULE5
    @(posedge REF_CLK) disable iff (RESET)
    !bypass_core_n |=> !LOOP_ENABLE)
    else $error("loop left enabled while bypass pin low");
  burst_addr_a: assert property ( // see RULE7
    @(posedge LINK_CLK) disable iff (link_rst)
    wr_stage_reg |=> mem[$past(wr_addr_reg[AW-1:1])]
      == ($past(wr_addr_reg[0]) ? {$past(word1_reg), $past(word2_reg)}
                                : {$past(word2_reg), $past(word1_reg)}))
    else $error("burst second word not placed at inverted bit 0");
  read_order_a: assert property ( // see RULE7
    @(posedge LINK_CLK) disable iff (link_rst)
    (rd_req_reg && !rd_valid_reg) |=> rd_pair_reg[DW-1:0] ==
      ($past(cmd_addr_reg[0]) ? $past(rd_entry[2*DW-1:DW])
                              : $past(rd_entry[DW-1:0])))
    else $error("first read word not from the loaded address");
  first_word_a: assert property ( // see RULE10
    @(posedge LINK_CLK) disable iff (link_rst)
    (ser_state_reg == OUT_FIRST && $changed(ser_state_reg)) |->
      $rose(echo_neg_reg) && doe_reg
      && (dout_reg == $past(buf_out_data[DW-1:0])))
    else $error("first read word not on the neg echo rise");
  second_word_a: assert property ( // see RULE10
    @(posedge LINK_CLK) disable iff (link_rst)
    (ser_state_reg == OUT_SECOND && $changed(ser_state_reg)) |->
      $rose(echo_pos_reg) && (dout_reg == $past(second_reg)))
    else $error("second read word not on the pos echo rise");
  k_timing_a: assert property ( // see RULE11
    @(posedge LINK_CLK) disable iff (link_rst)
    c_parked_s |=> single_mode_reg)
    else $error("parked output clock did not select K timing");
  write_take_a: assert property ( // see RULE12
    @(posedge LINK_CLK) disable iff (link_rst)
    write_cmd_s |=> wr_req_reg ##1 (wr_stage_reg && word1_reg == $past(DATA_IN)))
    else $error("write word not taken at the K rise after load");
  echo_source_a: assert property ( // see RULE13
    @(posedge LINK_CLK) disable iff (link_rst)
    (!k_mode && $rose(c_neg_s)) |=> (echo_pos_reg != $past(echo_pos_reg)))
    else $error("echo did not follow the output clock edge");
endmodule : ddr_sram_echo_clock_burst
`default_nettype wire

// >>> mem_ctrl_model.sv
// controller model: burst commands, write data and the output clock pair
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model #(
  parameter int AW = 19,
  parameter int DW = 36
) (
  input wire logic link_clk,
  output logic load_n,
  output logic read_nwrite,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] data_in,
  output logic out_clk_pos,
  output logic out_clk_neg
);
  // 0: pair held high, 1: pair running, 2: pair stopped
  logic [1:0] mode = 2'h0;
  logic div = 1'b0;
  initial begin
    load_n = 1'b1;
    read_nwrite = 1'b0;
    addr = '0;
    data_in = '0;
    out_clk_pos = 1'b1;
    out_clk_neg = 1'b1;
  end
  // output pair runs at a quarter of the link rate in mode 1; mode 0 holds it high and mode 2 stops it
  always @(posedge link_clk) begin
    div <= ~div;
    if (mode == 2'h0) begin
      out_clk_pos <= 1'b1;
      out_clk_neg <= 1'b1;
    end else if (mode == 2'h1) begin
      if (div) begin
        out_clk_pos <= ~out_clk_pos;
        out_clk_neg <= out_clk_pos;
      end
    end else begin
      out_clk_pos <= 1'b0;
      out_clk_neg <= 1'b1;
    end
  end
  task automatic set_mode(input logic [1:0] m);
    @(posedge link_clk);
    mode <= m;
  endtask : set_mode
  // load low for one rise, word 1 for the next rise, word 2 for its fall
  task automatic write_burst(input logic [AW-1:0] a,
                             input logic [DW-1:0] d1, d2);
    @(posedge link_clk);
    load_n <= 1'b0;
    read_nwrite <= 1'b0;
    addr <= a;
    @(posedge link_clk);
    load_n <= 1'b1;
    addr <= ~a;
    data_in <= d1;
    @(posedge link_clk);
    data_in <= d2;
  endtask : write_burst
  task automatic read_burst(input logic [AW-1:0] a);
    @(posedge link_clk);
    load_n <= 1'b0;
    read_nwrite <= 1'b1;
    addr <= a;
    @(posedge link_clk);
    load_n <= 1'b1;
    read_nwrite <= 1'b0;
    addr <= ~a;
  endtask : read_burst
endmodule : mem_ctrl_model
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the echo clock and burst block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DW = 36;
  localparam int AW = 19;
  localparam int CW = 8;
  localparam int CAL_PERIOD = 16;
  logic REF_CLK = 1'b0;
  logic LINK_CLK = 1'b0;
  logic RESET = 1'b1;
  logic LOOP_BYPASS_N = 1'b1;
  logic [CW-1:0] IMPEDANCE_PIN = 8'h3C;
  wire logic LOAD_N, READ_NWRITE, OUT_CLK_POS, OUT_CLK_NEG;
  wire logic [AW-1:0] ADDR;
  wire logic [DW-1:0] DATA_IN;
  logic [DW-1:0] DATA_OUT;
  logic [CW-1:0] IMPEDANCE_TRIM;
  logic DATA_OE, ECHO_OUT_POS, ECHO_OUT_NEG, LOOP_ENABLE;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  initial forever #4 REF_CLK = ~REF_CLK;
  initial begin
    #3;
    forever #7.5 LINK_CLK = ~LINK_CLK;
  end
  ddr_sram_echo_clock_burst #(.DW(DW), .AW(AW), .CW(CW),
    .CAL_PERIOD(CAL_PERIOD)) u_ddr_sram_echo_clock_burst (
    .REF_CLK(REF_CLK), .RESET(RESET), .LINK_CLK(LINK_CLK),
    .LOAD_N(LOAD_N), .READ_NWRITE(READ_NWRITE), .ADDR(ADDR),
    .DATA_IN(DATA_IN), .OUT_CLK_POS(OUT_CLK_POS),
    .OUT_CLK_NEG(OUT_CLK_NEG), .LOOP_BYPASS_N(LOOP_BYPASS_N),
    .IMPEDANCE_PIN(IMPEDANCE_PIN), .DATA_OUT(DATA_OUT),
    .DATA_OE(DATA_OE), .ECHO_OUT_POS(ECHO_OUT_POS),
    .ECHO_OUT_NEG(ECHO_OUT_NEG), .IMPEDANCE_TRIM(IMPEDANCE_TRIM),
    .LOOP_ENABLE(LOOP_ENABLE));
  mem_ctrl_model #(.AW(AW), .DW(DW)) u_mem_ctrl_model (
    .link_clk(LINK_CLK), .load_n(LOAD_N), .read_nwrite(READ_NWRITE),
    .addr(ADDR), .data_in(DATA_IN), .out_clk_pos(OUT_CLK_POS),
    .out_clk_neg(OUT_CLK_NEG));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("timeout reached");
      end_sim();
    end
  end
  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // words are judged on the far edge, once the launching rise has landed
  task automatic read_check(input logic [AW-1:0] a,
                            input logic [DW-1:0] e1, e2);
    int i;
    logic p;
    repeat (8) @(posedge LINK_CLK);
    u_mem_ctrl_model.read_burst(a);
    i = 0;
    while (DATA_OE !== 1'b1 && i < 40) begin
      @(negedge LINK_CLK);
      i++;
    end
    check("first word", e1, DATA_OUT);
    check("echo neg with first", 1'b1, ECHO_OUT_NEG);
    p = ECHO_OUT_POS;
    i = 0;
    while (!(p === 1'b0 && ECHO_OUT_POS === 1'b1) && i < 40) begin
      p = ECHO_OUT_POS;
      @(negedge LINK_CLK);
      i++;
    end
    check("second word", e2, DATA_OUT);
    check("enable on second", 1'b1, DATA_OE);
  endtask : read_check
  task automatic count_echo(input int n, output int t);
    logic p;
    t = 0;
    p = ECHO_OUT_POS;
    repeat (n) begin
      @(negedge LINK_CLK);
      if (ECHO_OUT_POS !== p) t++;
      p = ECHO_OUT_POS;
    end
    check("echo pair", 1'b1, ECHO_OUT_POS ^ ECHO_OUT_NEG);
  endtask : count_echo
  task automatic test_k_bursts;
    u_mem_ctrl_model.set_mode(2'h0);
    repeat (8) @(posedge LINK_CLK);
    u_mem_ctrl_model.write_burst(19'h00002, 36'h123456789, 36'hABCDEF012);
    u_mem_ctrl_model.write_burst(19'h00005, 36'h0F0F0F0F0, 36'h5A5A5A5A5);
    read_check(19'h00002, 36'h123456789, 36'hABCDEF012);
    read_check(19'h00005, 36'h0F0F0F0F0, 36'h5A5A5A5A5);
    read_check(19'h00004, 36'h5A5A5A5A5, 36'h0F0F0F0F0);
    $display("test k bursts done");
  endtask : test_k_bursts
  task automatic test_echo_modes;
    int t;
    repeat (8) @(posedge LINK_CLK);
    count_echo(20, t);
    check("k mode toggles", 20, t);
    check("idle enable", 1'b0, DATA_OE);
    u_mem_ctrl_model.set_mode(2'h1);
    repeat (12) @(posedge LINK_CLK);
    count_echo(40, t);
    check("c mode toggles", 20, t);
    read_check(19'h00003, 36'hABCDEF012, 36'h123456789);
    u_mem_ctrl_model.set_mode(2'h2);
    repeat (10) @(posedge LINK_CLK);
    count_echo(20, t);
    check("stopped toggles", 0, t);
    $display("test echo modes done");
  endtask : test_echo_modes
  task automatic test_bypass;
    int t;
    @(posedge REF_CLK);
    LOOP_BYPASS_N <= 1'b0;
    repeat (10) @(posedge REF_CLK);
    check("loop off", 1'b0, LOOP_ENABLE);
    repeat (8) @(posedge LINK_CLK);
    count_echo(20, t);
    check("bypass toggles", 20, t);
    @(posedge REF_CLK);
    LOOP_BYPASS_N <= 1'b1;
    repeat (10) @(posedge REF_CLK);
    check("loop on", 1'b1, LOOP_ENABLE);
    $display("test bypass done");
  endtask : test_bypass
  task automatic test_calibration;
    int i;
    check("first trim", 8'h3C, IMPEDANCE_TRIM);
    @(posedge REF_CLK);
    IMPEDANCE_PIN <= 8'hC3;
    i = 0;
    while (IMPEDANCE_TRIM !== 8'hC3 && i < 100) begin
      @(posedge REF_CLK);
      i++;
    end
    check("new trim", 8'hC3, IMPEDANCE_TRIM);
    check("trim delay", 1'b1, i <= CAL_PERIOD + 14);
    $display("test calibration done");
  endtask : test_calibration
  initial begin
    repeat (8) @(posedge REF_CLK);
    RESET <= 1'b0;
    repeat (8) @(posedge LINK_CLK);
    test_calibration();
    test_k_bursts();
    test_echo_modes();
    test_bypass();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
